/* shared/rnghg_pkg.sv */
package rnghg_pkg;

  localparam int unsigned OCTET_W      = 8;
  localparam int unsigned FIFO_DEPTH   = 16;
  // a run of this many equal raw bits counts as loss of entropy
  localparam int unsigned TF_RUN_LIMIT = 32;
  localparam int unsigned RUN_CNT_W    = 6;
  // online test: ones count over a window of raw bits
  localparam int unsigned WIN_BITS     = 256;
  localparam int unsigned WIN_POS_W    = 8;
  localparam int unsigned ONES_W       = 9;
  localparam int unsigned ONES_MIN     = 96;
  localparam int unsigned ONES_MAX     = 160;
  // entropy claim carried by released bits, in millibits per bit
  localparam int unsigned ENTROPY_MILLI = 997;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_STARTUP = 4'h2,
    ST_RUN     = 4'h4,
    ST_FAIL    = 4'h8
  } rnghg_state_type;

endpackage

/* hw/rnghg_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module rnghg_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  input  wire logic             i_flush,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign o_out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign o_in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign o_out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = i_ce && !i_flush && i_in_valid && o_in_ready;
  assign pop         = i_ce && !i_flush && o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* hw/rnghg_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - every health check looks at the raw bits of the physical entropy source.
// RULE2 - from start-up on, a run of equal raw bits flags total entropy loss in the same cycle it completes; the code sets o_total_fail one cycle later.
// RULE3 - while total failure is flagged, no octet is offered to the consumer.
// RULE4 - octets only use raw bits older than the failure run, and everything queued is flushed on failure.
// RULE5 - a ones-count window test checks the raw stream at start-up and keeps running afterwards.
// RULE6 - output stays blocked until the first window passes, and is blocked again on any defect.
// RULE7 - the window test runs continuously, one window after another.
// RULE8 - the self-test sequence starts only on a software start request.
// RULE9 - a single held pass flag reports the outcome of the self-test sequence.
// RULE10 - released bits are packed and delivered as whole octets.
// RULE11 - o_valid goes low whenever start-up is pending, total failure or a defect is flagged.
module rnghg_top (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // entropy source pin
  input  wire logic        i_raw_bit,
  // software control and status
  input  wire logic        i_start,
  output logic             o_busy,
  output logic             o_pass,
  output logic             o_total_fail,
  output logic             o_defect,
  // random octet stream
  output logic [7:0]       o_data,
  output logic             o_valid,
  input  wire logic        i_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // raw bit synchroniser and health tests

  logic                                  raw_meta_reg;
  logic                                  raw_sync_reg;
  logic                                  prev_bit_reg;
  logic [rnghg_pkg::RUN_CNT_W-1:0]       run_len_reg;
  logic [rnghg_pkg::WIN_POS_W-1:0]       win_pos_reg;
  logic [rnghg_pkg::ONES_W-1:0]          ones_reg;
  logic [rnghg_pkg::ONES_W-1:0]          ones_total;
  rnghg_pkg::rnghg_state_type            state_reg;
  logic                                  testing;
  logic                                  tf_hit;
  logic                                  win_end;
  logic                                  defect_hit;
  logic                                  start_ok;
  logic                                  kill;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      raw_meta_reg <= 1'b0;
      raw_sync_reg <= 1'b0;
    end else if (i_ce) begin
      raw_meta_reg <= i_raw_bit;
      raw_sync_reg <= raw_meta_reg;
    end
  end

  assign testing  = (state_reg == rnghg_pkg::ST_STARTUP) || (state_reg == rnghg_pkg::ST_RUN);
  assign start_ok = i_start && ((state_reg == rnghg_pkg::ST_IDLE) || (state_reg == rnghg_pkg::ST_FAIL)); // see RULE8

  // first sample after start never counts as a repeat, so a stale bit cannot trip the test
  assign tf_hit = testing && (run_len_reg != '0) && (raw_sync_reg == prev_bit_reg) &&
                  (run_len_reg == rnghg_pkg::RUN_CNT_W'(rnghg_pkg::TF_RUN_LIMIT - 1)); // see RULE1 see RULE2

  assign ones_total = ones_reg + rnghg_pkg::ONES_W'(raw_sync_reg);
  assign win_end    = (win_pos_reg == rnghg_pkg::WIN_POS_W'(rnghg_pkg::WIN_BITS - 1));
  assign defect_hit = testing && win_end &&
                      ((ones_total < rnghg_pkg::ONES_W'(rnghg_pkg::ONES_MIN)) ||
                       (ones_total > rnghg_pkg::ONES_W'(rnghg_pkg::ONES_MAX))); // see RULE5
  assign kill       = tf_hit || defect_hit;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_bit_reg <= 1'b0;
      run_len_reg  <= '0;
    end else if (i_ce) begin
      if (!testing) begin
        run_len_reg <= '0;
      end else begin
        prev_bit_reg <= raw_sync_reg;
        if ((run_len_reg != '0) && (raw_sync_reg == prev_bit_reg)) begin
          if (run_len_reg != rnghg_pkg::RUN_CNT_W'(rnghg_pkg::TF_RUN_LIMIT)) begin
            run_len_reg <= run_len_reg + 1'b1;
          end
        end else begin
          run_len_reg <= rnghg_pkg::RUN_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      win_pos_reg <= '0;
      ones_reg    <= '0;
    end else if (i_ce) begin
      if (!testing || win_end) begin // see RULE7
        win_pos_reg <= '0;
        ones_reg    <= '0;
      end else begin
        win_pos_reg <= win_pos_reg + 1'b1;
        ones_reg    <= ones_total;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequence and status

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= rnghg_pkg::ST_IDLE;
    end else if (i_ce) begin
      unique case (state_reg)
        rnghg_pkg::ST_IDLE, rnghg_pkg::ST_FAIL: begin
          if (start_ok) begin
            state_reg <= rnghg_pkg::ST_STARTUP;
          end
        end
        rnghg_pkg::ST_STARTUP: begin
          if (kill) begin
            state_reg <= rnghg_pkg::ST_FAIL;
          end else if (win_end) begin
            state_reg <= rnghg_pkg::ST_RUN; // see RULE6
          end
        end
        rnghg_pkg::ST_RUN: begin
          if (kill) begin
            state_reg <= rnghg_pkg::ST_FAIL; // see RULE6
          end
        end
        default: state_reg <= rnghg_pkg::ST_IDLE;
      endcase
    end
  end

  // hits only occur while testing and clears only while not, so the two never meet
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy       <= 1'b0;
      o_pass       <= 1'b0;
      o_total_fail <= 1'b0;
      o_defect     <= 1'b0;
    end else if (i_ce) begin
      if (start_ok) begin
        o_busy       <= 1'b1;
        o_pass       <= 1'b0;
        o_total_fail <= 1'b0;
        o_defect     <= 1'b0;
      end else begin
        if (tf_hit) begin
          o_total_fail <= 1'b1; // see RULE2
        end
        if (defect_hit) begin
          o_defect <= 1'b1;
        end
        if (kill) begin
          o_busy <= 1'b0;
          o_pass <= 1'b0; // see RULE9
        end else if ((state_reg == rnghg_pkg::ST_STARTUP) && win_end) begin
          o_busy <= 1'b0;
          o_pass <= 1'b1; // see RULE9
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // delay line and octet assembly

  // a bit is released only once it is older than any run that could still trip the test
  logic [rnghg_pkg::TF_RUN_LIMIT-1:0]    delay_reg;
  logic [rnghg_pkg::RUN_CNT_W-1:0]       fill_reg;
  logic                                  delay_full;
  logic [7:0]                            octet_reg;
  logic [2:0]                            bit_cnt_reg;
  logic [7:0]                            pend_reg;
  logic                                  pend_valid_reg;
  logic                                  fifo_in_ready;
  logic                                  assemble;
  logic                                  running;

  assign running    = (state_reg == rnghg_pkg::ST_RUN) && !kill;
  assign delay_full = (fill_reg == rnghg_pkg::RUN_CNT_W'(rnghg_pkg::TF_RUN_LIMIT));
  // back-pressure: while the pending octet cannot move, released bits are dropped
  assign assemble   = running && delay_full && !(pend_valid_reg && !fifo_in_ready);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      delay_reg <= '0;
      fill_reg  <= '0;
    end else if (i_ce) begin
      if (!testing || kill) begin
        fill_reg <= '0; // see RULE4
      end else begin
        delay_reg <= {delay_reg[rnghg_pkg::TF_RUN_LIMIT-2:0], raw_sync_reg};
        if (!delay_full) begin
          fill_reg <= fill_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      octet_reg      <= '0;
      bit_cnt_reg    <= '0;
      pend_reg       <= '0;
      pend_valid_reg <= 1'b0;
    end else if (i_ce) begin
      if (!running) begin
        bit_cnt_reg    <= '0;
        pend_valid_reg <= 1'b0; // see RULE3 see RULE4
      end else begin
        if (pend_valid_reg && fifo_in_ready) begin
          pend_valid_reg <= 1'b0;
        end
        if (assemble) begin
          octet_reg   <= {octet_reg[6:0], delay_reg[rnghg_pkg::TF_RUN_LIMIT-1]};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
          if (bit_cnt_reg == 3'h7) begin
            pend_reg       <= {octet_reg[6:0], delay_reg[rnghg_pkg::TF_RUN_LIMIT-1]}; // see RULE10
            pend_valid_reg <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer and output stage

  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       take;

  assign take = running && fifo_out_valid && (!o_valid || i_ready);

  rnghg_fifo #(
    .WIDTH (rnghg_pkg::OCTET_W),
    .DEPTH (rnghg_pkg::FIFO_DEPTH)
  ) i_rnghg_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_ce        (i_ce),
    .i_flush     (!running), // see RULE4
    .i_in_valid  (pend_valid_reg),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (pend_reg),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (take),
    .o_out_data  (fifo_out_data)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_data  <= '0;
    end else if (i_ce) begin
      if (!running) begin
        o_valid <= 1'b0; // see RULE11 see RULE3 see RULE6
      end else if (take) begin
        o_valid <= 1'b1;
        o_data  <= fifo_out_data;
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* sim/rnghg_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module rnghg_chk (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rstn,
  // watched ports
  input wire logic       i_ce,
  input wire logic       i_raw_bit,
  input wire logic       i_start,
  input wire logic       o_busy,
  input wire logic       o_pass,
  input wire logic       o_total_fail,
  input wire logic       o_defect,
  input wire logic [7:0] o_data,
  input wire logic       o_valid,
  input wire logic       i_ready
);
  logic [9:0] busy_cnt;
  logic [6:0] run_cnt;
  logic       last_raw;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) busy_cnt <= 10'h000;
    else if (i_ce) busy_cnt <= o_busy ? busy_cnt + 10'h001 : 10'h000;
  end

  // pin run length, counted only while a test is active; frozen cycles are not samples
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_cnt  <= 7'h00;
      last_raw <= 1'b0;
    end else if (i_ce) begin
      last_raw <= i_raw_bit;
      if (!(o_busy || o_pass) || i_raw_bit != last_raw) run_cnt <= 7'h01;
      else if (run_cnt != 7'h7F) run_cnt <= run_cnt + 7'h01;
    end
  end

  ////////////////////////////////
  sequence s_start_taken; i_ce && i_start && !o_busy && !o_pass; endsequence
  sequence s_test_begun; o_busy && !o_pass && !o_total_fail && !o_defect; endsequence
  property p_start; s_start_taken |=> s_test_begun; endproperty
  a_start: assert property (p_start) else $error("start not answered");
  property p_refuse; i_ce && i_start && o_pass |=> !o_busy; endproperty
  a_refuse: assert property (p_refuse) else $error("start taken while running");
  property p_fail_block; o_total_fail |-> !o_valid; endproperty
  a_fail_block: assert property (p_fail_block) else $error("octet offered on total failure");
  property p_defect_block; o_defect |-> !o_valid; endproperty
  a_defect_block: assert property (p_defect_block) else $error("octet offered on defect");
  property p_busy_block; o_busy |-> !o_valid; endproperty
  a_busy_block: assert property (p_busy_block) else $error("octet offered during start-up");
  property p_valid_pass; o_valid |-> o_pass; endproperty
  a_valid_pass: assert property (p_valid_pass) else $error("octet offered without pass");
  property p_hold; o_valid && !i_ready |=> (o_valid && $stable(o_data)) || !o_pass; endproperty
  a_hold: assert property (p_hold) else $error("octet changed before taken");
  property p_window; $rose(o_pass) |-> busy_cnt >= 10'h0FF && busy_cnt <= 10'h101; endproperty
  a_window: assert property (p_window) else $error("pass not at window end");
  property p_window_max; busy_cnt <= 10'h101; endproperty
  a_window_max: assert property (p_window_max) else $error("start-up window too long");
  property p_detect; $rose(o_total_fail) |-> run_cnt >= 7'h1E && run_cnt <= 7'h26; endproperty
  a_detect: assert property (p_detect) else $error("total failure at wrong run length");
  property p_pass_held; o_pass |=> o_pass || o_total_fail || o_defect; endproperty
  a_pass_held: assert property (p_pass_held) else $error("pass dropped without cause");
endmodule

bind rnghg_top rnghg_chk i_rnghg_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_raw_bit(i_raw_bit),
  .i_start(i_start), .o_busy(o_busy), .o_pass(o_pass), .o_total_fail(o_total_fail), .o_defect(o_defect),
  .o_data(o_data), .o_valid(o_valid), .i_ready(i_ready));

`default_nettype wire

/* sim/rnghg_sw_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rnghg_sw_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // stall control
  input  wire logic       i_stall,
  // octet stream
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  // tallies
  output int              o_octets,
  output int              o_bad
);
  initial o_ready = 1'b0;
  always @(negedge i_clk) o_ready <= i_rstn && !i_stall;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_octets <= 0;
      o_bad    <= 0;
    end else if (i_valid && o_ready) begin
      o_octets <= o_octets + 1;
      // the bench source alternates, so any other octet holds bits of a stuck run
      if (i_data !== 8'hAA && i_data !== 8'h55) o_bad <= o_bad + 1;
    end
  end
endmodule

`default_nettype wire

/* sim/rng_health_output_gate_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rng_health_output_gate_tb;
  logic       i_clk;
  logic       i_rstn;
  logic       i_raw_bit;
  logic       i_start;
  logic       i_ready;
  logic       stall;
  logic       ce;
  logic       o_busy;
  logic       o_pass;
  logic       o_total_fail;
  logic       o_defect;
  logic       o_valid;
  logic [7:0] o_data;
  logic [7:0] flg;
  int         octets;
  int         bad;
  int         errors;
  int         tests_run;
  int         mode;
  int         ph;

  assign flg = {3'h0, o_busy, o_pass, o_total_fail, o_defect, o_valid};

  rnghg_top i_rnghg_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_raw_bit(i_raw_bit), .i_start(i_start),
    .o_busy(o_busy), .o_pass(o_pass), .o_total_fail(o_total_fail), .o_defect(o_defect), .o_data(o_data),
    .o_valid(o_valid), .i_ready(i_ready));
  rnghg_sw_model i_rnghg_sw_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_stall(stall), .i_valid(o_valid),
    .i_data(o_data), .o_ready(i_ready), .o_octets(octets), .o_bad(bad));

  ////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // entropy source: 0 alternating, 1 stuck low, 2 too few ones, 3 too many ones
  always @(negedge i_clk) begin
    ph <= ph + 1;
    case (mode)
      0: i_raw_bit <= ph[0];
      1: i_raw_bit <= 1'b0;
      2: i_raw_bit <= (ph % 4 == 0);
      default: i_raw_bit <= (ph % 3 != 0);
    endcase
  end

  ////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_n(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic start_req;
    i_start = 1'b1;
    cyc(1);
    i_start = 1'b0;
  endtask

  ////////////////////////////////
  task automatic t_good;
    int base;
    base  = octets;
    mode  = 0;
    stall = 1'b1;
    cyc(4);
    start_req;
    chk("start flags", 8'h10, flg);
    cyc(300);
    chk("run flags", 8'h09, flg);
    cyc(300);
    stall = 1'b0;
    cyc(60);
    // full buffer plus held octet, then only a few fresh ones: bits are dropped while full
    chk_n("drained", 1, int'(octets - base >= 17 && octets - base <= 26));
    chk_n("bad octets", 0, bad);
    $display("t_good done");
  endtask

  task automatic t_refuse;
    start_req;
    cyc(2);
    chk("refused start", 8'h08, flg & 8'hFE);
    $display("t_refuse done");
  endtask

  task automatic t_stuck;
    mode = 1;
    cyc(45);
    chk("stuck in run", 8'h04, flg);
    chk_n("bad octets", 0, bad);
    $display("t_stuck done");
  endtask

  task automatic t_defect;
    for (int p = 2; p < 4; p++) begin
      mode = p;
      start_req;
      chk("restart flags", 8'h10, flg);
      cyc(300);
      chk("defect flags", 8'h02, flg);
    end
    $display("t_defect done");
  endtask

  task automatic t_stuck_start;
    mode = 1;
    start_req;
    cyc(45);
    chk("stuck at start", 8'h04, flg);
    $display("t_stuck_start done");
  endtask

  // a stuck pin while the enable is low must not be seen, and the held octet must not move
  task automatic t_freeze;
    logic [7:0] held;
    stall = 1'b1;
    cyc(20);
    chk("pre-freeze flags", 8'h09, flg);
    held = o_data;
    ce   = 1'b0;
    mode = 1;
    cyc(60);
    chk("frozen flags", 8'h09, flg);
    chk("frozen data", held, o_data);
    ce = 1'b1;
    cyc(45);
    chk("thawed flags", 8'h04, flg);
    chk_n("bad octets", 0, bad);
    $display("t_freeze done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////
  initial begin
    errors    = 0;
    tests_run = 0;
    mode      = 0;
    ph        = 0;
    stall     = 1'b0;
    ce        = 1'b1;
    i_start   = 1'b0;
    i_raw_bit = 1'b0;
    i_rstn    = 1'b0;
    cyc(3);
    i_rstn = 1'b1;
    cyc(1);
    chk("reset flags", 8'h00, flg);
    t_good;
    t_refuse;
    t_stuck;
    t_defect;
    t_stuck_start;
    t_good;
    t_freeze;
    tally_and_finish;
  end

  // tests need about 2200 cycles
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
